// ---- inc/lcf_pkg.sv ----
// Purpose: Shared constants and types for the logic/call/flag-clear executor
// Assumes: 16-bit instruction words, 4-bit data path, 32-bit register bus
// Notes:   Byte offsets are word aligned
package lcf_pkg;
    // Widths and depths
    localparam int unsigned LCF_DATA_W    = 32;
    localparam int unsigned LCF_ADDR_W    = 6;
    localparam int unsigned LCF_NIB_W     = 4;
    localparam int unsigned LCF_MEM_AW    = 7;
    localparam int unsigned LCF_MEM_DEPTH = 128;
    localparam int unsigned LCF_PC_W      = 11;
    localparam int unsigned LCF_DIV_W     = 14;
    localparam int unsigned LCF_DIV_LOW_W = 4;
    localparam int unsigned LCF_STK_DEPTH = 8;
    localparam int unsigned LCF_EVT_W     = 8;
    // Register byte offsets
    localparam logic [5:0] LCF_OFS_INSTR = 6'h00;
    localparam logic [5:0] LCF_OFS_ACCUM = 6'h04;
    localparam logic [5:0] LCF_OFS_FLAGS = 6'h08;
    localparam logic [5:0] LCF_OFS_PROG  = 6'h0C;
    localparam logic [5:0] LCF_OFS_EVENT = 6'h10;
    localparam logic [5:0] LCF_OFS_DIV   = 6'h14;
    localparam logic [5:0] LCF_OFS_STACK = 6'h18;
    localparam logic [5:0] LCF_OFS_MADDR = 6'h1C;
    localparam logic [5:0] LCF_OFS_MDATA = 6'h20;
    // Field positions
    localparam int unsigned LCF_FLG_CARRY   = 0;
    localparam int unsigned LCF_FLG_ZERO    = 1;
    localparam int unsigned LCF_FLG_UNSUP   = 2;
    localparam int unsigned LCF_FLG_STK_OVF = 3;
    localparam int unsigned LCF_EVT_RSVD    = 3;
    localparam int unsigned LCF_EVT_DIV     = 0;
    localparam int unsigned LCF_STK_TOP_LSB = 16;
    // Reset values
    localparam logic [15:0] LCF_RST_INSTR = 16'h0000;
    localparam logic [3:0]  LCF_RST_NIB   = 4'h0;
    localparam logic [3:0]  LCF_RST_FLAGS = 4'h0;
    localparam logic [10:0] LCF_RST_PROG  = 11'h000;
    localparam logic [13:0] LCF_RST_DIV   = 14'h0000;
    localparam logic [7:0]  LCF_RST_EVT   = 8'h00;
    localparam logic [6:0]  LCF_RST_MADDR = 7'h00;
    // Opcode patterns
    localparam logic [8:0]  LCF_OPC_AND_MEM    = 9'h054;
    localparam logic [8:0]  LCF_OPC_AND_MEM_WB = 9'h056;
    localparam logic [7:0]  LCF_OPC_AND_IMM    = 8'h2E;
    localparam logic [7:0]  LCF_OPC_AND_IMM_WB = 8'h2F;
    localparam logic [4:0]  LCF_OPC_CALL       = 5'h0C;
    localparam logic [15:0] LCF_OPC_CARRY_ZERO = 16'h5000;
    localparam logic [15:0] LCF_OPC_DIV_RESET  = 16'h4100;
    localparam logic [7:0]  LCF_OPC_EVT_MASK   = 8'h40;
    // Decoded operation
    typedef enum logic [3:0] {
        LCF_OP_NONE       = 4'b0000,
        LCF_OP_AND_MEM    = 4'b0001,
        LCF_OP_AND_IMM    = 4'b0010,
        LCF_OP_AND_MEM_WB = 4'b0011,
        LCF_OP_AND_IMM_WB = 4'b0100,
        LCF_OP_CALL       = 4'b0101,
        LCF_OP_CARRY_ZERO = 4'b0110,
        LCF_OP_DIV_RESET  = 4'b0111,
        LCF_OP_EVT_MASK   = 4'b1000
    } lcf_op_t;
endpackage

// ---- inc/lcf_dec_if.sv ----
// Purpose: Carrier between executor and instruction decoder
// Assumes: Word is valid only in the executing cycle
// Notes:   Purely combinational signals
`timescale 1ns/1ns
`default_nettype none
interface lcf_dec_if;
    import lcf_pkg::*;
    logic [15:0] word;
    logic        valid;
    lcf_op_t     op;
    logic [6:0]  mem_addr;
    logic [3:0]  imm;
    logic [3:0]  wreg;
    logic [10:0] target;
    logic [7:0]  mask;
    modport dec  (input word, valid, output op, mem_addr, imm, wreg, target, mask);
    modport core (output word, valid, input op, mem_addr, imm, wreg, target, mask);
endinterface
`default_nettype wire

// ---- src/lcf_decoder.sv ----
// Purpose: Field split and opcode match of one instruction word
// Assumes: Only the listed group is recognised
// Notes:   Anything else decodes as LCF_OP_NONE
`timescale 1ns/1ns
`default_nettype none
module lcf_decoder (
    // Decode carrier
    lcf_dec_if.dec d
);
    import lcf_pkg::*;

    assign d.mem_addr = d.word[6:0];
    assign d.imm      = d.word[7:4];
    assign d.wreg     = d.word[3:0];
    assign d.target   = d.word[10:0];
    assign d.mask     = d.word[7:0];

    always_comb begin
        d.op = LCF_OP_NONE;
        if (d.valid) begin
            if (d.word[15:7] == LCF_OPC_AND_MEM) begin
                d.op = LCF_OP_AND_MEM;
            end else if (d.word[15:7] == LCF_OPC_AND_MEM_WB) begin
                d.op = LCF_OP_AND_MEM_WB;
            end else if (d.word[15:8] == LCF_OPC_AND_IMM) begin
                d.op = LCF_OP_AND_IMM;
            end else if (d.word[15:8] == LCF_OPC_AND_IMM_WB) begin
                d.op = LCF_OP_AND_IMM_WB;
            end else if (d.word[15:11] == LCF_OPC_CALL) begin
                d.op = LCF_OP_CALL;
            end else if (d.word == LCF_OPC_CARRY_ZERO) begin
                d.op = LCF_OP_CARRY_ZERO;
            end else if (d.word == LCF_OPC_DIV_RESET) begin
                d.op = LCF_OP_DIV_RESET;
            end else if (d.word[15:8] == LCF_OPC_EVT_MASK) begin
                d.op = LCF_OP_EVT_MASK;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/lcf_core.sv ----
// Purpose: Executes AND forms, call, carry clear, divider and event clears
// Assumes: One instruction per accepted write to the instruction register
// Notes:   Avalon-MM slave, every access answers on its second edge
// Functional notes
// - Memory AND loads accumulator, zero flag only
// - Register-immediate AND loads accumulator, zero only
// - Memory AND writes memory and accumulator
// - Register-immediate AND writes register and accumulator
// - Call pushes next address, loads target
// - Carry clear zeroes carry, nothing else
// - Divider reset clears low four stages only
// - Event mask ones clear matching event flags
// - Bits 0-2: divider, timer0, port change
// - Bit 4 clears pin edge; bit 3 reserved
// - Bits 5-6 clear serial receive and transmit
// - Bit 7 clears timer1 underflow flag
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module lcf_core #(
    parameter int unsigned STK_DEPTH = lcf_pkg::LCF_STK_DEPTH,
    parameter int unsigned DIV_W     = lcf_pkg::LCF_DIV_W
) (
    // Clock and reset
    input  wire logic                            core_clk_in,
    input  wire logic                            reset_in,
    // Avalon-MM slave
    input  wire logic [lcf_pkg::LCF_ADDR_W-1:0]  avs_address_in,
    input  wire logic                            avs_read_in,
    input  wire logic                            avs_write_in,
    input  wire logic [lcf_pkg::LCF_DATA_W-1:0]  avs_writedata_in,
    input  wire logic [3:0]                      avs_byteenable_in,
    output logic      [lcf_pkg::LCF_DATA_W-1:0]  avs_readdata_out,
    output logic                                 avs_waitrequest_out,
    // Peripheral event pulses
    input  wire logic [lcf_pkg::LCF_EVT_W-1:0]   event_set_in,
    // Core state
    output logic      [lcf_pkg::LCF_NIB_W-1:0]   accumulator_out,
    output logic                                 zero_flag_out,
    output logic                                 carry_flag_out,
    output logic      [lcf_pkg::LCF_PC_W-1:0]    program_counter_out,
    output logic      [lcf_pkg::LCF_EVT_W-1:0]   event_flag_bank_out,
    output logic      [DIV_W-1:0]                prescale_divider_zero_out
);
    import lcf_pkg::*;

    localparam int unsigned SP_W  = $clog2(STK_DEPTH + 1);
    localparam int unsigned IDX_W = $clog2(STK_DEPTH);
    localparam logic [SP_W-1:0] SP_FULL = SP_W'(STK_DEPTH);

    // Bus handshake
    logic                  ack;
    logic                  bus_req;
    logic                  wr_go;
    logic [LCF_DATA_W-1:0] wdata;
    logic                  exec;

    // Architectural state
    logic [3:0]            accumulator;
    logic                  zero_flag;
    logic                  carry_flag;
    logic                  unsup_flag;
    logic                  stk_ovf_flag;
    logic [LCF_PC_W-1:0]   program_counter;
    logic [LCF_EVT_W-1:0]  event_flag_bank;
    logic [DIV_W-1:0]      prescale_divider_zero;
    logic [15:0]           last_instr;
    logic [6:0]            mem_ptr;
    logic [3:0]            mem [LCF_MEM_DEPTH];
    logic [LCF_PC_W-1:0]   stack [STK_DEPTH];
    logic [SP_W-1:0]       stack_ptr;

    // Datapath
    logic [6:0]            op_addr;
    logic [3:0]            op_a;
    logic [3:0]            op_b;
    logic [3:0]            and_res;
    logic                  is_and;
    logic                  mem_we;
    logic [6:0]            mem_wa;
    logic [3:0]            mem_wd;
    logic [LCF_PC_W-1:0]   next_pc;
    logic [LCF_EVT_W-1:0]  evt_set;
    logic [LCF_EVT_W-1:0]  evt_clear;
    logic                  div_wrap;
    logic [LCF_PC_W-1:0]   stack_top;
    logic [LCF_DATA_W-1:0] next_rdata;

    lcf_dec_if dif ();

    lcf_decoder u_dec (
        .d (dif.dec)
    );

    // One wait cycle per access keeps read data a flop
    assign bus_req             = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~ack;
    assign wr_go               = avs_write_in & ack;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wdata[8*b +: 8] = avs_byteenable_in[b] ? avs_writedata_in[8*b +: 8] : 8'h00;
    end

    // Instruction needs both low lanes
    assign exec = wr_go && (avs_address_in == LCF_OFS_INSTR) && (avs_byteenable_in[1:0] == 2'h3);

    assign dif.word  = avs_writedata_in[15:0];
    assign dif.valid = exec;

    // AND operand selection
    always_comb begin
        op_addr = dif.mem_addr;
        op_b    = accumulator;
        is_and  = 1'b0;
        case (dif.op)
            LCF_OP_AND_MEM, LCF_OP_AND_MEM_WB: begin
                is_and = 1'b1;
            end
            LCF_OP_AND_IMM, LCF_OP_AND_IMM_WB: begin
                op_addr = {3'h0, dif.wreg};
                op_b    = dif.imm;
                is_and  = 1'b1;
            end
            default: begin
                is_and = 1'b0;
            end
        endcase
    end

    assign op_a    = mem[op_addr];
    assign and_res = op_a & op_b;

    // Memory write port: write-back forms or bus data window
    always_comb begin
        mem_we = 1'b0;
        mem_wa = op_addr;
        mem_wd = and_res;
        if (dif.op == LCF_OP_AND_MEM_WB || dif.op == LCF_OP_AND_IMM_WB) begin
            mem_we = 1'b1;
        end else if (wr_go && avs_address_in == LCF_OFS_MDATA && avs_byteenable_in[0]) begin
            mem_we = 1'b1;
            mem_wa = mem_ptr;
            mem_wd = wdata[3:0];
        end
    end

    for (genvar i = 0; i < LCF_MEM_DEPTH; i++) begin : g_mem
        always_ff @(posedge core_clk_in) begin
            if (reset_in) begin
                mem[i] <= LCF_RST_NIB;
            end else if (mem_we && mem_wa == LCF_MEM_AW'(i)) begin
                mem[i] <= mem_wd;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mem_ptr <= LCF_RST_MADDR;
        end else if (wr_go && avs_address_in == LCF_OFS_MADDR && avs_byteenable_in[0]) begin
            mem_ptr <= wdata[6:0];
        end
    end

    // Accumulator
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            accumulator <= LCF_RST_NIB;
        end else if (is_and) begin
            accumulator <= and_res;
        end else if (wr_go && avs_address_in == LCF_OFS_ACCUM && avs_byteenable_in[0]) begin
            accumulator <= wdata[3:0];
        end
    end

    // Zero and carry; carry is untouched by the AND forms
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            zero_flag  <= LCF_RST_FLAGS[LCF_FLG_ZERO];
            carry_flag <= LCF_RST_FLAGS[LCF_FLG_CARRY];
        end else if (is_and) begin
            zero_flag <= (and_res == LCF_RST_NIB);
        end else if (dif.op == LCF_OP_CARRY_ZERO) begin
            carry_flag <= 1'b0;
        end else if (wr_go && avs_address_in == LCF_OFS_FLAGS && avs_byteenable_in[0]) begin
            zero_flag  <= wdata[LCF_FLG_ZERO];
            carry_flag <= wdata[LCF_FLG_CARRY];
        end
    end

    // Sticky diagnostics; a write of one clears, a new event wins
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            unsup_flag   <= LCF_RST_FLAGS[LCF_FLG_UNSUP];
            stk_ovf_flag <= LCF_RST_FLAGS[LCF_FLG_STK_OVF];
        end else begin
            if (exec && dif.op == LCF_OP_NONE) begin
                unsup_flag <= 1'b1;
            end else if (wr_go && avs_address_in == LCF_OFS_FLAGS && wdata[LCF_FLG_UNSUP]) begin
                unsup_flag <= 1'b0;
            end
            if (dif.op == LCF_OP_CALL && stack_ptr == SP_FULL) begin
                stk_ovf_flag <= 1'b1;
            end else if (wr_go && avs_address_in == LCF_OFS_FLAGS && wdata[LCF_FLG_STK_OVF]) begin
                stk_ovf_flag <= 1'b0;
            end
        end
    end

    // Program counter
    always_comb begin
        next_pc = program_counter;
        if (dif.op == LCF_OP_CALL) begin
            next_pc = dif.target;
        end else if (exec) begin
            next_pc = program_counter + LCF_PC_W'(1);
        end else if (wr_go && avs_address_in == LCF_OFS_PROG && avs_byteenable_in[1:0] == 2'h3) begin
            next_pc = wdata[LCF_PC_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            program_counter <= LCF_RST_PROG;
        end else begin
            program_counter <= next_pc;
        end
    end

    // Return stack; a push past full holds the pointer at full, overwrites entry 0 and is not to be trusted
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            stack_ptr <= '0;
        end else if (dif.op == LCF_OP_CALL && stack_ptr != SP_FULL) begin
            stack_ptr <= stack_ptr + SP_W'(1);
        end
    end

    for (genvar s = 0; s < STK_DEPTH; s++) begin : g_stack
        always_ff @(posedge core_clk_in) begin
            if (reset_in) begin
                stack[s] <= LCF_RST_PROG;
            end else if (dif.op == LCF_OP_CALL && stack_ptr[IDX_W-1:0] == IDX_W'(s)) begin
                stack[s] <= program_counter + LCF_PC_W'(1);
            end
        end
    end

    assign stack_top = (stack_ptr == '0) ? LCF_RST_PROG : stack[IDX_W'(stack_ptr - SP_W'(1))];

    // Divider 0 free runs; only its low stages are cleared
    assign div_wrap = &prescale_divider_zero;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            prescale_divider_zero <= DIV_W'(LCF_RST_DIV);
        end else if (dif.op == LCF_OP_DIV_RESET) begin
            prescale_divider_zero[LCF_DIV_LOW_W-1:0] <= '0;
        end else begin
            prescale_divider_zero <= prescale_divider_zero + DIV_W'(1);
        end
    end

    // Event flags: set beats clear in the same cycle
    always_comb begin
        evt_set = event_set_in;
        evt_set[LCF_EVT_DIV]  = event_set_in[LCF_EVT_DIV] | div_wrap;
        evt_set[LCF_EVT_RSVD] = 1'b0;
        evt_clear = '0;
        if (dif.op == LCF_OP_EVT_MASK) begin
            evt_clear = dif.mask;
            evt_clear[LCF_EVT_RSVD] = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            event_flag_bank <= LCF_RST_EVT;
        end else begin
            event_flag_bank <= (event_flag_bank & ~evt_clear) | evt_set;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            last_instr <= LCF_RST_INSTR;
        end else if (exec) begin
            last_instr <= dif.word;
        end
    end

    // Read mux, captured during the wait cycle
    always_comb begin
        next_rdata = '0;
        case (avs_address_in)
            LCF_OFS_INSTR: begin
                next_rdata[15:0] = last_instr;
            end
            LCF_OFS_ACCUM: begin
                next_rdata[3:0] = accumulator;
            end
            LCF_OFS_FLAGS: begin
                next_rdata[LCF_FLG_CARRY]   = carry_flag;
                next_rdata[LCF_FLG_ZERO]    = zero_flag;
                next_rdata[LCF_FLG_UNSUP]   = unsup_flag;
                next_rdata[LCF_FLG_STK_OVF] = stk_ovf_flag;
            end
            LCF_OFS_PROG: begin
                next_rdata[LCF_PC_W-1:0] = program_counter;
            end
            LCF_OFS_EVENT: begin
                next_rdata[LCF_EVT_W-1:0] = event_flag_bank;
            end
            LCF_OFS_DIV: begin
                next_rdata[DIV_W-1:0] = prescale_divider_zero;
            end
            LCF_OFS_STACK: begin
                next_rdata[SP_W-1:0] = stack_ptr;
                next_rdata[LCF_STK_TOP_LSB +: LCF_PC_W] = stack_top;
            end
            LCF_OFS_MADDR: begin
                next_rdata[6:0] = mem_ptr;
            end
            LCF_OFS_MDATA: begin
                next_rdata[3:0] = mem[mem_ptr];
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            avs_readdata_out <= '0;
        end else if (avs_read_in && !ack) begin
            avs_readdata_out <= next_rdata;
        end
    end

    assign accumulator_out           = accumulator;
    assign zero_flag_out             = zero_flag;
    assign carry_flag_out            = carry_flag;
    assign program_counter_out       = program_counter;
    assign event_flag_bank_out       = event_flag_bank;
    assign prescale_divider_zero_out = prescale_divider_zero;
endmodule
`default_nettype wire

// ---- sim/lcf_core_assertions.sv ----
// Purpose: Port checks for lcf_core
// Assumes: Master holds each request until waitrequest is low
// Notes:   Divider overflow also feeds event bit 0, so clear checks skip it
`timescale 1ns/1ns
`default_nettype none
module lcf_core_assertions
    import lcf_pkg::*;
#(
    parameter int unsigned DIV_W = 14
) (
    // Clock, reset and bus
    input wire logic             core_clk_in,
    input wire logic             reset_in,
    input wire logic [5:0]       avs_address_in,
    input wire logic             avs_read_in,
    input wire logic             avs_write_in,
    input wire logic [31:0]      avs_writedata_in,
    input wire logic [3:0]       avs_byteenable_in,
    input wire logic             avs_waitrequest_out,
    // Events and core state
    input wire logic [7:0]       event_set_in,
    input wire logic [3:0]       accumulator_out,
    input wire logic             zero_flag_out,
    input wire logic             carry_flag_out,
    input wire logic [10:0]      program_counter_out,
    input wire logic [7:0]       event_flag_bank_out,
    input wire logic [DIV_W-1:0] prescale_divider_zero_out
);
    logic        exec_w;
    logic [15:0] word;
    assign word = avs_writedata_in[15:0];
    // Effect lands at the edge where waitrequest is low
    assign exec_w = avs_write_in && !avs_waitrequest_out && avs_address_in == LCF_OFS_INSTR
                    && avs_byteenable_in[1:0] == 2'b11;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    idle_nowait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("waitrequest high while idle");
    one_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("more than one wait cycle");
    and_flags_a: assert property (exec_w && (word[15:7] == LCF_OPC_AND_MEM || word[15:7] == LCF_OPC_AND_MEM_WB
        || word[15:9] == 7'h17) |=> zero_flag_out == (accumulator_out == 4'h0) && $stable(carry_flag_out))
        else $error("AND flag update wrong");
    and_imm_a: assert property (exec_w && word[15:9] == 7'h17 |=>
        (accumulator_out & ~$past(avs_writedata_in[7:4])) == 4'h0) else $error("AND immediate result wrong");
    call_pc_a: assert property (exec_w && word[15:11] == LCF_OPC_CALL |=>
        program_counter_out == $past(avs_writedata_in[10:0])) else $error("call target not loaded");
    pc_step_a: assert property (exec_w && word[15:11] != LCF_OPC_CALL |=>
        program_counter_out == $past(program_counter_out) + 11'h001) else $error("pc did not step");
    carry_zero_a: assert property (exec_w && word == LCF_OPC_CARRY_ZERO |=> !carry_flag_out
        && $stable(accumulator_out) && $stable(zero_flag_out)) else $error("carry clear wrong");
    div_low_a: assert property (exec_w && word == LCF_OPC_DIV_RESET |=> prescale_divider_zero_out[3:0] == 4'h0
        && prescale_divider_zero_out[DIV_W-1:4] == $past(prescale_divider_zero_out[DIV_W-1:4]))
        else $error("divider reset wrong");
    div_count_a: assert property (!reset_in && !(exec_w && word == LCF_OPC_DIV_RESET) |=>
        prescale_divider_zero_out == $past(prescale_divider_zero_out) + 1'b1) else $error("divider not counting");
    evt_clear_a: assert property (exec_w && word[15:8] == LCF_OPC_EVT_MASK |=>
        ((event_flag_bank_out ^ $past(event_set_in)) & $past(avs_writedata_in[7:0]) & 8'hF6) == 8'h00)
        else $error("masked event not cleared");
    evt_keep_a: assert property (exec_w && word[15:8] == LCF_OPC_EVT_MASK |=>
        ($past(event_flag_bank_out) & ~$past(avs_writedata_in[7:0]) & ~event_flag_bank_out) == 8'h00)
        else $error("unmasked event lost");
    rsvd_bit_a: assert property (event_flag_bank_out[3] == 1'b0) else $error("reserved event set");
    evt_set_a: assert property (|event_set_in |=>
        (event_flag_bank_out & $past(event_set_in) & 8'hF7) == ($past(event_set_in) & 8'hF7))
        else $error("event not set");
    cover property (exec_w && word[15:11] == LCF_OPC_CALL);
    cover property (exec_w && word[15:8] == LCF_OPC_EVT_MASK && |event_set_in);
    cover property (exec_w && word == LCF_OPC_DIV_RESET);
endmodule
bind lcf_core lcf_core_assertions #(.DIV_W(DIV_W)) chk_u (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_waitrequest_out(avs_waitrequest_out), .event_set_in(event_set_in), .accumulator_out(accumulator_out),
    .zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out), .program_counter_out(program_counter_out),
    .event_flag_bank_out(event_flag_bank_out), .prescale_divider_zero_out(prescale_divider_zero_out));
`default_nettype wire

// ---- sim/logic_call_flagclear_ops_tb_top.sv ----
// Purpose: Self-checking bench for lcf_core
// Assumes: Run ends long before the divider overflows
// Notes:   Model state lives in integers and a queue
`timescale 1ns/1ns
`default_nettype none
module logic_call_flagclear_ops_tb_top;
    import lcf_pkg::*;
    logic        clk, rst, rd_q, wr_q, wait_w, zf_w, cf_w;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat, tmp;
    logic [3:0]  be, acc_w, iv;
    logic [7:0]  evs, evb;
    logic [10:0] pc_w;
    logic [13:0] div_w, div_m;
    logic [6:0]  av;
    logic [15:0] w;
    int          n_errors, cmp_count, m_acc, m_z, m_c, m_pc, m_ev, m_hold, m_mem[128];
    int          m_stk[$];
    lcf_core dut_u (.core_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd_q),
        .avs_write_in(wr_q), .avs_writedata_in(wdat), .avs_byteenable_in(be), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wait_w), .event_set_in(evs), .accumulator_out(acc_w), .zero_flag_out(zf_w),
        .carry_flag_out(cf_w), .program_counter_out(pc_w), .event_flag_bank_out(evb),
        .prescale_divider_zero_out(div_w));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst)
            div_m <= '0;
        else if (wr_q && !wait_w && adr == LCF_OFS_INSTR && wdat[15:0] == LCF_OPC_DIV_RESET)
            div_m <= {div_m[13:4], 4'h0};
        else
            div_m <= div_m + 14'h0001;
    end
    task automatic give_verdict();
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One idle cycle between accesses keeps each strobe to one assignment per step
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_q <= wr;
        rd_q <= !wr;
        do begin
            @(negedge clk);
            n++;
        end while (wait_w !== 1'b0 && n < 16);
        if (wait_w !== 1'b0) begin
            n_errors++;
            give_verdict();
        end
        @(posedge clk);
        q = rdat;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    task automatic exec(input logic [15:0] i);
        int a, r;
        bus(1'b1, LCF_OFS_INSTR, {16'h0000, i}, tmp);
        m_ev = (m_ev | m_hold) & 'hF7;
        if (i[15:9] == 7'h17 || i[15:7] == LCF_OPC_AND_MEM || i[15:7] == LCF_OPC_AND_MEM_WB) begin
            a = (i[15:9] == 7'h17) ? i[3:0] : i[6:0];
            r = m_mem[a] & ((i[15:9] == 7'h17) ? i[7:4] : m_acc);
            m_acc = r;
            m_z = (r == 0);
            if (i[8])
                m_mem[a] = r;
        end
        if (i == LCF_OPC_CARRY_ZERO)
            m_c = 0;
        if (i[15:8] == LCF_OPC_EVT_MASK)
            m_ev = ((m_ev & ~i[7:0]) | m_hold) & 'hF7;
        if (i[15:11] == LCF_OPC_CALL) begin
            m_stk.push_back((m_pc + 1) % 2048);
            m_pc = i[10:0];
        end else
            m_pc = (m_pc + 1) % 2048;
        @(negedge clk);
        chk("accumulator", m_acc, acc_w);
        chk("zero flag", m_z, zf_w);
        chk("carry flag", m_c, cf_w);
        chk("program counter", m_pc, pc_w);
        chk("event flags", m_ev, evb);
        chk("divider", div_m, div_w);
    endtask
    initial begin
        rst = 1'b1;
        {rd_q, wr_q, adr, wdat, evs} = '0;
        be = 4'hF;
        {n_errors, cmp_count, m_acc, m_z, m_c, m_pc, m_ev, m_hold} = '0;
        foreach (m_mem[k])
            m_mem[k] = 0;
        void'($urandom(32'h05328b68));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b1, 6'h3C, 32'hFFFFFFFF, tmp);
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, 6'(k * 4 + 4), '0, tmp);
            if (k != 4)
                chk("reset read", 0, tmp);
        end
        for (int k = 0; k < 48; k++) begin
            av = 7'($urandom);
            iv = 4'($urandom);
            if (k % 4 >= 2)
                av[6:4] = 3'b000;
            m_mem[av] = $urandom % 16;
            m_acc = $urandom % 16;
            m_c = $urandom % 2;
            m_z = 0;
            bus(1'b1, LCF_OFS_MADDR, 32'(av), tmp);
            bus(1'b1, LCF_OFS_MDATA, m_mem[av], tmp);
            bus(1'b1, LCF_OFS_ACCUM, m_acc, tmp);
            bus(1'b1, LCF_OFS_FLAGS, m_c, tmp);
            w = (k % 4 == 0) ? {LCF_OPC_AND_MEM, av} : (k % 4 == 1) ? {LCF_OPC_AND_MEM_WB, av}
                : (k % 4 == 2) ? {LCF_OPC_AND_IMM, iv, av[3:0]} : {LCF_OPC_AND_IMM_WB, iv, av[3:0]};
            exec(w);
            bus(1'b0, LCF_OFS_MDATA, '0, tmp);
            chk("memory", m_mem[av], tmp);
        end
        bus(1'b1, LCF_OFS_FLAGS, 32'h3, tmp);
        m_c = 1;
        m_z = 1;
        exec(LCF_OPC_CARRY_ZERO);
        exec(LCF_OPC_DIV_RESET);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            evs <= 8'hFF;
            @(posedge clk);
            evs <= 8'h00;
            m_ev = 'hF7;
            exec({LCF_OPC_EVT_MASK, 8'(1 << k)});
        end
        m_hold = 'h22;
        @(posedge clk);
        evs <= 8'h22;
        exec({LCF_OPC_EVT_MASK, 8'hFF});
        @(posedge clk);
        evs <= 8'h00;
        m_hold = 0;
        m_pc = $urandom % 2048;
        bus(1'b1, LCF_OFS_PROG, m_pc, tmp);
        for (int k = 1; k <= 9; k++) begin
            exec({LCF_OPC_CALL, 11'($urandom)});
            bus(1'b0, LCF_OFS_STACK, '0, tmp);
            if (k <= 8)
                chk("stack", (m_stk[$] << 16) | k, tmp);
            else
                chk("stack depth", 8, tmp & 'hF);
        end
        bus(1'b0, LCF_OFS_FLAGS, '0, tmp);
        chk("flags", 'hA, tmp);
        give_verdict();
    end
endmodule
`default_nettype wire
